// [rtl/adcsc_regs.vh]
// Register map, field positions and timing constants of the
// converter sequencing control.
// Assumes inclusion by bare name from the rtl/ files and the bench.
`ifndef ADCSC_REGS_VH
`define ADCSC_REGS_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define ADCSC_IDX_CTRL 10'h01F
`define ADCSC_IDX_CFG 10'h09F
`define ADCSC_IDX_RESH 10'h0A0
`define ADCSC_IDX_RESL 10'h0A1
`define ADCSC_IDX_STAT 10'h0A2
`define ADCSC_IDX_MASK 10'h0A3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ADCSC_CLK_RST 2'h0
`define ADCSC_CHAN_RST 3'h0
`define ADCSC_PCFG_RST 4'h0
`define ADCSC_RES_RST 10'h000

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ADCSC_CTL_CLK_HI 7
`define ADCSC_CTL_CLK_LO 6
`define ADCSC_CTL_CHS_HI 5
`define ADCSC_CTL_CHS_LO 3
`define ADCSC_CTL_GO 2
`define ADCSC_CTL_ON 0
`define ADCSC_CFG_ALIGN 7
`define ADCSC_CFG_PCFG_HI 3
`define ADCSC_CFG_PCFG_LO 0
`define ADCSC_STAT_DONE 0

// ------------------------------------------------------------
// Conversion clock selection and timing
// ------------------------------------------------------------
`define ADCSC_CLK_DIV2 2'h0
`define ADCSC_CLK_DIV8 2'h1
`define ADCSC_CLK_DIV32 2'h2
`define ADCSC_CLK_RC 2'h3
`define ADCSC_DIV2_LAST 5'h01
`define ADCSC_DIV8_LAST 5'h07
`define ADCSC_DIV32_LAST 5'h1F
`define ADCSC_RECOV_LAST 2'h1
`define ADCSC_SAR_HOLD 4'h0
`define ADCSC_SAR_LSB_STEP 4'hA
`define ADCSC_SAR_LAST 4'hB
`define ADCSC_SAR_MSB 10'h200

`endif

// [rtl/adcsc_sar.v]
// Successive-approximation sequencer: one hold period, ten bit
// trials and one closing period, each one conversion bit period.
// Assumes tad_tick is a one-cycle pulse per bit period and
// comp_in is high while the held level is at or above dac_code.
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_regs.vh"

module adcsc_sar (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Sequencing
  input wire start,
  input wire abort,
  input wire tad_tick,
  output reg busy,
  output reg done,
  // Analog side
  input wire comp_in,
  output reg [9:0] dac_code,
  output reg [9:0] result
);

  reg [3:0] step;
  reg [9:0] mask;
  wire [9:0] decided = comp_in ? dac_code : (dac_code & ~mask);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      step <= 4'h0;
      mask <= 10'h000;
      dac_code <= 10'h000;
      result <= `ADCSC_RES_RST;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        busy <= 1'b0;
        dac_code <= 10'h000;
      end
      else if (start && !busy)
      begin
        busy <= 1'b1;
        step <= `ADCSC_SAR_HOLD;
        dac_code <= 10'h000;
        mask <= 10'h000;
      end
      else if (busy && tad_tick)
      begin
        step <= step + 4'h1;
        if (step == `ADCSC_SAR_HOLD)
        begin
          // Hold period over: first trial at the MSB
          mask <= `ADCSC_SAR_MSB;
          dac_code <= `ADCSC_SAR_MSB;
        end
        else if (step == `ADCSC_SAR_LAST)
        begin
          // Last trial left the final code; it loads together with done
          busy <= 1'b0;
          done <= 1'b1;
          result <= dac_code;
        end
        else
        begin
          // Keep or drop the trial bit, then try the next one
          mask <= mask >> 1;
          dac_code <= decided | (mask >> 1);
        end
      end
    end
  end

endmodule // adcsc_sar
`default_nettype wire

// [rtl/adcsc_top.v]
// Converter sequencing control: AHB-Lite register slave, conversion
// clock generation, acquisition/conversion/recovery sequencing,
// result alignment and completion interrupt.
// Assumes a single AHB-Lite master with hreadyout fed back as
// hready, and an analog front end with sample switch, reference
// muxes and comparator outside this block.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_regs.vh"

//Behaviour
//- Five channels picked by control bits 5:3
//- Held sample, not live pin, feeds conversion
//- Successive approximation yields a 10-bit code
//- Upper and lower references software selectable
//- RC conversion clock keeps converting during sleep
//- Result high, result low, control, configuration registers
//- Pins set analog or digital, one reference
//- Completion loads result, clears go, sets flag
//- Alignment bit picks right or left justification
//- Two bit periods before next acquisition
module adcsc_top (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Interrupt
  output wire irq,
  // Device state
  input wire sleep_mode,
  input wire rc_osc_tick,
  // Analog front end
  input wire comp_in,
  output wire [2:0] conv_channel,
  output wire converter_power_on,
  output wire sample_connect,
  output wire [9:0] dac_code,
  output wire [4:0] pin_analog_en,
  output wire vref_pos_pin,
  output wire vref_neg_pin
);

  localparam ST_ACQ = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_RECOV = 2'h2;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  reg [1:0] conv_clock_select;
  reg [2:0] channel_select;
  reg go_flag;
  reg power_on;
  reg result_alignment_select;
  reg [3:0] pin_function_sel;
  reg conversion_complete_flag;
  reg done_mask;

  reg [1:0] state;
  reg [1:0] recov_cnt;
  reg [4:0] div_cnt;
  reg [4:0] div_last;

  wire sar_done;
  wire [9:0] sar_result;

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  reg dp_write;
  reg dp_read;
  reg rd_wait;
  reg [9:0] dp_idx;
  reg [7:0] rd_byte;
  reg [7:0] result_high_byte;
  reg [7:0] result_low_byte;

  wire access = hsel && hready && htrans[1];

  // Reads take one wait state so hrdata comes from a flip-flop
  assign hreadyout = ~(dp_read && !rd_wait);
  assign hresp = 1'b0;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_idx <= 10'h000;
      rd_wait <= 1'b0;
    end
    else
    begin
      if (hreadyout)
      begin
        dp_write <= access && hwrite;
        dp_read <= access && !hwrite;
        dp_idx <= haddr[11:2];
      end
      rd_wait <= dp_read && !rd_wait;
    end
  end

  wire wr_ctrl = dp_write && (dp_idx == `ADCSC_IDX_CTRL);
  wire wr_cfg = dp_write && (dp_idx == `ADCSC_IDX_CFG);
  wire wr_stat = dp_write && (dp_idx == `ADCSC_IDX_STAT);
  wire wr_mask = dp_write && (dp_idx == `ADCSC_IDX_MASK);

  // ------------------------------------------------------------
  // Result alignment
  // ------------------------------------------------------------
  always @*
  begin
    if (result_alignment_select)
    begin
      result_high_byte = {6'h00, sar_result[9:8]};
      result_low_byte = sar_result[7:0];
    end
    else
    begin
      result_high_byte = sar_result[9:2];
      result_low_byte = {sar_result[1:0], 6'h00};
    end
  end

  // ------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------
  always @*
  begin
    case (dp_idx)
      `ADCSC_IDX_CTRL:
        rd_byte = {conv_clock_select, channel_select, go_flag,
                   1'b0, power_on};
      `ADCSC_IDX_CFG:
        rd_byte = {result_alignment_select, 3'h0,
                   pin_function_sel};
      `ADCSC_IDX_RESH:
        rd_byte = result_high_byte;
      `ADCSC_IDX_RESL:
        rd_byte = result_low_byte;
      `ADCSC_IDX_STAT:
        rd_byte = {7'h00, conversion_complete_flag};
      `ADCSC_IDX_MASK:
        rd_byte = {7'h00, done_mask};
      default:
        rd_byte = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h00000000;
    else if (dp_read && !rd_wait)
      hrdata <= {24'h000000, rd_byte};
  end

  // ------------------------------------------------------------
  // Control and configuration registers
  // ------------------------------------------------------------
  // Go only starts with the power bit set in the same write
  wire start_req = wr_ctrl && hwdata[`ADCSC_CTL_GO] &&
                   hwdata[`ADCSC_CTL_ON];
  wire next_power = wr_ctrl ? hwdata[`ADCSC_CTL_ON] : power_on;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_clock_select <= `ADCSC_CLK_RST;
      channel_select <= `ADCSC_CHAN_RST;
      power_on <= 1'b0;
      go_flag <= 1'b0;
      result_alignment_select <= 1'b0;
      pin_function_sel <= `ADCSC_PCFG_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        conv_clock_select <=
          hwdata[`ADCSC_CTL_CLK_HI:`ADCSC_CTL_CLK_LO];
        channel_select <=
          hwdata[`ADCSC_CTL_CHS_HI:`ADCSC_CTL_CHS_LO];
        power_on <= hwdata[`ADCSC_CTL_ON];
      end
      // Writing zero to go does not abort a running conversion
      if (!next_power)
        go_flag <= 1'b0;
      else if (start_req)
        go_flag <= 1'b1;
      else if (sar_done)
        go_flag <= 1'b0;
      if (wr_cfg)
      begin
        result_alignment_select <= hwdata[`ADCSC_CFG_ALIGN];
        pin_function_sel <=
          hwdata[`ADCSC_CFG_PCFG_HI:`ADCSC_CFG_PCFG_LO];
      end
    end
  end

  // ------------------------------------------------------------
  // Completion interrupt
  // ------------------------------------------------------------
  // A completion in the cycle of a clearing write wins
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conversion_complete_flag <= 1'b0;
      done_mask <= 1'b0;
    end
    else
    begin
      if (sar_done)
        conversion_complete_flag <= 1'b1;
      else if (wr_stat && hwdata[`ADCSC_STAT_DONE])
        conversion_complete_flag <= 1'b0;
      if (wr_mask)
        done_mask <= hwdata[`ADCSC_STAT_DONE];
    end
  end

  assign irq = conversion_complete_flag && done_mask;

  // ------------------------------------------------------------
  // Conversion clock
  // ------------------------------------------------------------
  always @*
  begin
    case (conv_clock_select)
      `ADCSC_CLK_DIV2: div_last = `ADCSC_DIV2_LAST;
      `ADCSC_CLK_DIV8: div_last = `ADCSC_DIV8_LAST;
      `ADCSC_CLK_DIV32: div_last = `ADCSC_DIV32_LAST;
      default: div_last = `ADCSC_DIV32_LAST;
    endcase
  end

  // The system clock stops in sleep, so divided ticks are gated
  // there; only the private RC oscillator keeps ticking.
  wire use_rc = (conv_clock_select == `ADCSC_CLK_RC);
  wire osc_run = power_on && !use_rc && !sleep_mode;
  wire div_tick = osc_run && (div_cnt >= div_last);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= 5'h00;
    else if (!osc_run || div_tick)
      div_cnt <= 5'h00;
    else
      div_cnt <= div_cnt + 5'h01;
  end

  // Changing the clock select mid-conversion stretches or shortens one period
  wire tad_tick = use_rc ? (rc_osc_tick && power_on)
                         : div_tick;

  // ------------------------------------------------------------
  // Acquisition, conversion and recovery sequencing
  // ------------------------------------------------------------
  wire sar_start = (state == ST_ACQ) && go_flag && power_on;
  wire sar_abort = !power_on;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_ACQ;
      recov_cnt <= 2'h0;
    end
    else if (!power_on)
    begin
      state <= ST_ACQ;
      recov_cnt <= 2'h0;
    end
    else
    begin
      case (state)
        ST_ACQ:
          if (sar_start)
            state <= ST_CONV;
        ST_CONV:
          if (sar_done)
          begin
            state <= ST_RECOV;
            recov_cnt <= 2'h0;
          end
        // A go written during recovery waits until it ends
        ST_RECOV:
          if (tad_tick)
          begin
            recov_cnt <= recov_cnt + 2'h1;
            if (recov_cnt == `ADCSC_RECOV_LAST)
              state <= ST_ACQ;
          end
        default:
          state <= ST_ACQ;
      endcase
    end
  end

  // Switch closed only while acquiring; open during conversion
  // so the held charge, not the pin, is converted.
  assign sample_connect = power_on && (state == ST_ACQ) &&
                          !go_flag;

  adcsc_sar u_sar (
    .clk(clk),
    .rst_n(rst_n),
    .start(sar_start),
    .abort(sar_abort),
    .tad_tick(tad_tick),
    .busy(),
    .done(sar_done),
    .comp_in(comp_in),
    .dac_code(dac_code),
    .result(sar_result)
  );

  // ------------------------------------------------------------
  // Pin function and reference decode
  // ------------------------------------------------------------
  reg [6:0] pin_map;

  // Map is {vref_pos, vref_neg, analog enables AN4..AN0}
  always @*
  begin
    case (pin_function_sel)
      4'h0, 4'h2, 4'h9: pin_map = 7'h1F;
      4'h1, 4'h3, 4'hA: pin_map = 7'h57;
      4'h4: pin_map = 7'h0B;
      4'h5: pin_map = 7'h43;
      4'h6, 4'h7: pin_map = 7'h00;
      4'h8, 4'hB, 4'hC: pin_map = 7'h73;
      4'hD: pin_map = 7'h63;
      4'hE: pin_map = 7'h01;
      default: pin_map = 7'h61;
    endcase
  end

  assign pin_analog_en = pin_map[4:0];
  assign vref_pos_pin = pin_map[6];
  assign vref_neg_pin = pin_map[5];
  assign conv_channel = channel_select;
  assign converter_power_on = power_on;

endmodule // adcsc_top
`default_nettype wire

// [test/adcsc_monitor.sv]
// Assertion checker for the converter sequencing control.
// Assumes it is bound to adcsc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adcsc_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Front end
  input wire logic converter_power_on,
  input wire logic sample_connect,
  input wire logic [2:0] conv_channel,
  input wire logic [4:0] pin_analog_en
);
  logic take;
  logic wr_dp;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign take = hsel && hready && htrans[1];
  // Settings may only move at the edge that ends a write data phase
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      wr_dp <= 1'b0;
    else
      wr_dp <= take && hwrite;
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take one wait state");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_byte_lane: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  a_off_no_sample: assert property (!converter_power_on |-> !sample_connect)
    else $error("sample switch closed while powered off");
  a_chan_by_write: assert property ($changed(conv_channel) |-> $past(wr_dp))
    else $error("channel changed without a write");
  a_power_by_write: assert property ($changed(converter_power_on) |-> $past(wr_dp))
    else $error("power changed without a write");
  a_map_by_write: assert property ($changed(pin_analog_en) |-> $past(wr_dp))
    else $error("pin map changed without a write");
endmodule // adcsc_monitor

bind adcsc_top adcsc_monitor i_mon (.clk, .rst_n, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .converter_power_on,
  .sample_connect, .conv_channel, .pin_analog_en);
`default_nettype wire

// [test/adcsc_afe.sv]
// Analog front end model: channel pins, hold capacitor, comparator.
// Assumes the bench sets one 10-bit level per channel.
`timescale 1ns/1ps
`default_nettype none
module adcsc_afe (
  // Clock and levels
  input wire logic clk,
  input wire logic [49:0] levels,
  // Converter side
  input wire logic [2:0] conv_channel,
  input wire logic sample_connect,
  input wire logic [9:0] dac_code,
  output logic comp_in
);
  logic [9:0] held = 10'h000;
  // Only a closed switch charges the cap; absent channels read ground
  always @(posedge clk)
    if (sample_connect)
      held <= (conv_channel < 3'h5) ? levels[conv_channel*10 +: 10] : 10'h000;
  assign comp_in = (held >= dac_code);
endmodule // adcsc_afe
`default_nettype wire

// [test/adcsc_top_tb.sv]
// Self-checking bench for the converter sequencing control.
// Assumes the AHB-Lite slave is alone, so hreadyout is hready.
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_regs.vh"
module adcsc_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sleep_mode = 1'b0;
  logic rc_osc_tick = 1'b0;
  logic [49:0] levels = 50'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, comp_in, power_on, sample_connect;
  logic vref_pos_pin, vref_neg_pin;
  logic [2:0] conv_channel;
  logic [9:0] dac_code;
  logic [4:0] pin_analog_en;
  logic [2:0] rc_cnt = 3'h0;
  logic [31:0] rd;
  logic [15:0] row;
  logic [9:0] lv;
  int failures = 0;
  int check_count = 0;
  // Rows: clock select, channel, alignment, input level
  logic [15:0] rows [6] = '{16'h07FF, 16'h4800, 16'h9555, 16'hDAAA,
    16'h2201, 16'h45FE};
  localparam logic [15:0] VP = 16'hBD2A;
  localparam logic [15:0] VN = 16'hB900;
  localparam logic [31:0] A_CTRL = {20'h0, `ADCSC_IDX_CTRL, 2'h0};
  localparam logic [31:0] A_CFG = {20'h0, `ADCSC_IDX_CFG, 2'h0};
  localparam logic [31:0] A_RESH = {20'h0, `ADCSC_IDX_RESH, 2'h0};
  localparam logic [31:0] A_RESL = {20'h0, `ADCSC_IDX_RESL, 2'h0};
  localparam logic [31:0] A_STAT = {20'h0, `ADCSC_IDX_STAT, 2'h0};
  localparam logic [31:0] A_MASK = {20'h0, `ADCSC_IDX_MASK, 2'h0};

  always #4 clk = ~clk;
  // RC oscillator stand-in: one tick every five cycles
  always @(posedge clk)
  begin
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    rc_osc_tick <= (rc_cnt == 3'h4);
  end

  adcsc_top i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .sleep_mode(sleep_mode),
    .rc_osc_tick(rc_osc_tick), .comp_in(comp_in),
    .conv_channel(conv_channel), .converter_power_on(power_on),
    .sample_connect(sample_connect), .dac_code(dac_code),
    .pin_analog_en(pin_analog_en), .vref_pos_pin(vref_pos_pin),
    .vref_neg_pin(vref_neg_pin));
  adcsc_afe i_afe (.clk(clk), .levels(levels), .conv_channel(conv_channel),
    .sample_connect(sample_connect), .dac_code(dac_code), .comp_in(comp_in));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Returns at the falling edge after the transfer has landed
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(negedge clk);
    while (!hreadyout) @(negedge clk);
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(negedge clk);
    while (!hreadyout) @(negedge clk);
    rd = hrdata;
    @(negedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Polls the go bit; a stuck conversion shows in the later compare
  task automatic poll();
    rd = 32'h4;
    for (int k = 0; k < 200 && rd[2] !== 1'b0; k++)
      bus(1'b0, A_CTRL, 32'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wr(A_MASK, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      row = rows[i];
      lv = row[9:0];
      @(posedge clk);
      for (int c = 0; c < 5; c++)
        levels[c*10 +: 10] <= (c == row[13:11]) ? lv : ~lv;
      sleep_mode <= (row[15:14] == `ADCSC_CLK_RC);
      wr(A_CFG, {24'h0, row[10], 7'h0});
      // Select and power first, so the hold cap charges before go
      wr(A_CTRL, {24'h0, row[15:11], 3'h1});
      chk(conv_channel, row[13:11]);
      repeat (80) @(posedge clk);
      chk(sample_connect, 1'b1);
      wr(A_CTRL, {24'h0, row[15:11], 3'h5});
      chk(sample_connect, 1'b0);
      poll();
      chk(irq, 1'b1);
      rdc(A_RESH, row[10] ? {30'h0, lv[9:8]} : {24'h0, lv[9:2]});
      rdc(A_RESL, row[10] ? {24'h0, lv[7:0]} : {24'h0, lv[1:0], 6'h0});
      rdc(A_CTRL, {24'h0, row[15:11], 3'h1});
      wr(A_STAT, 32'h1);
      chk(irq, 1'b0);
    end
    wr(A_CTRL, 32'hC6);
    chk(power_on, 1'b0);
    rdc(A_CTRL, 32'hC0);
    chk(sample_connect, 1'b0);
    wr(A_CTRL, 32'h85);
    rdc(A_CTRL, 32'h85);
    wr(A_CTRL, 32'h0);
    rdc(A_CTRL, 32'h0);
    rdc(A_STAT, 32'h0);
    @(posedge clk);
    sleep_mode <= 1'b1;
    wr(A_CTRL, 32'h85);
    repeat (300) @(posedge clk);
    rdc(A_CTRL, 32'h85);
    @(posedge clk);
    sleep_mode <= 1'b0;
    poll();
    rdc(A_STAT, 32'h1);
    chk(sample_connect, 1'b0);
    repeat (80) @(posedge clk);
    chk(sample_connect, 1'b1);
    wr(A_MASK, 32'h0);
    chk(irq, 1'b0);
    wr(A_MASK, 32'h1);
    chk(irq, 1'b1);
    for (int c = 0; c < 16; c++)
    begin
      wr(A_CFG, {24'h0, 4'h7, c[3:0]});
      rdc(A_CFG, {28'h0, c[3:0]});
      chk(vref_pos_pin, VP[c]);
      chk(vref_neg_pin, VN[c]);
      if (c == 4)
        chk(pin_analog_en, 32'hB);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk(irq, 1'b0);
    chk(pin_analog_en, 32'h1F);
    rdc(A_CTRL, 32'h0);
    rdc(A_CFG, 32'h0);
    rdc(A_RESH, 32'h0);
    rdc(A_STAT, 32'h0);
    rdc(32'h0, 32'h0);
    finish_test();
  end
endmodule // adcsc_top_tb
`default_nettype wire
